// >>> rtl/pam_area_dec.sv
// Area decoder: eight equal areas sized by the address space in force.
// Assumes a 24-bit CPU address.
`timescale 1ns/1ps
`include "pam_consts.svh"
module pam_area_dec
  import pam_pkg::*;
(
  input wire logic [1:0] spaceSel,
  input wire logic [23:0] cpuAddr,
  output logic [2:0] areaNum,
  output logic onChipRegs
);
  always_comb begin
    case (spaceSel)
      `PAM_SPACE_16M: begin
        areaNum = cpuAddr[`PAM_AREA_SHIFT_16M +: 3];
        onChipRegs = cpuAddr[23:8] == 16'hffff;
      end
      `PAM_SPACE_64K: begin
        areaNum = cpuAddr[`PAM_AREA_SHIFT_64K +: 3];
        onChipRegs = cpuAddr[15:8] == 8'hff;
      end
      default: begin
        areaNum = cpuAddr[`PAM_AREA_SHIFT_1M +: 3];
        onChipRegs = cpuAddr[19:8] == 12'hfff;
      end
    endcase
  end
endmodule // pam_area_dec

// >>> rtl/pam_consts.svh
// Constants of the mode-dependent port and address multiplexer.
// Assumes inclusion by the design modules; definitions only.
`ifndef PAM_CONSTS_SVH
`define PAM_CONSTS_SVH

`define PAM_ADDR_CTRL 8'h00
`define PAM_BUS_REL 8'h04
`define PAM_P1_DIR 8'h08
`define PAM_P2_DIR 8'h0c
`define PAM_P5_DIR 8'h10
`define PAM_STATUS 8'h14
`define PAM_UPPER_LSB 5
`define PAM_UPPER_RST 8'he0
`define PAM_BUS_REL_RST 8'hff
`define PAM_DIR_RST 8'h00
`define PAM_AREA_SHIFT_1M 17
`define PAM_AREA_SHIFT_16M 21
`define PAM_AREA_SHIFT_64K 13
`define PAM_SPACE_64K 2'h0
`define PAM_SPACE_1M 2'h1
`define PAM_SPACE_16M 2'h2
`define PAM_BUS_WIDTH_8 1'b0

`endif

// >>> rtl/pam_pin_sel.sv
// One pin selector: address function or general port function.
// Assumes the general port data and direction come from port logic outside.
`timescale 1ns/1ps
module pam_pin_sel #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] addrEn,
  input wire logic [WIDTH-1:0] addrBits,
  input wire logic [WIDTH-1:0] gpOut,
  input wire logic [WIDTH-1:0] gpDir,
  output logic [WIDTH-1:0] pinOut,
  output logic [WIDTH-1:0] pinOe
);
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      pinOut[i] = addrEn[i] ? addrBits[i] : gpOut[i];
      pinOe[i] = addrEn[i] | gpDir[i];
    end
  end
endmodule // pam_pin_sel

// >>> rtl/pam_pkg.sv
// Types shared by the port and address multiplexer files.
// Assumes nothing beyond the constants header.
package pam_pkg;
  typedef enum logic [2:0] {
    PAM_MODE_NONE = 3'b000,
    PAM_MODE_1 = 3'b001,
    PAM_MODE_2 = 3'b010,
    PAM_MODE_3 = 3'b011,
    PAM_MODE_4 = 3'b100,
    PAM_MODE_5 = 3'b101,
    PAM_MODE_6 = 3'b110,
    PAM_MODE_7 = 3'b111
  } pam_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pam_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pam_apb_rsp_t;

  typedef struct packed {
    logic [7:0] p1Oe;
    logic [7:0] p2Oe;
    logic [3:0] p5Oe;
    logic [3:0] paOe;
    logic [7:0] p1Out;
    logic [7:0] p2Out;
    logic [3:0] p5Out;
    logic [3:0] paOut;
    logic [7:0] p3Oe;
    logic [7:0] p3Out;
  } pam_pins_t;
endpackage

// >>> rtl/pam_port_mux.sv
// Mode-dependent assignment of ports 1, 2, 3, 5 and A to the external bus.
// Assumes synchronous inputs on ref_clk and an APB master for the registers.
//
// Overview of operation
// - Mode 1 drives A19..A0 on ports 1, 2, 5; one megabyte space.
// - Every expanded mode starts with an 8-bit bus, all areas 8-bit.
// - Mode 3 drives A23..A0 on ports 1, 2, 5 and port A.
// - Mode 3 upper three address pins enable only after zeros in bits 7..5.
// - Mode 3 pin for A20 is always an address output.
// - Mode 5 ports 1, 2, 5 come up as inputs after reset.
// - Mode 5 pin becomes address output when its direction bit is one.
// - Mode 6 is single-chip, 64 kbyte space, all ports general.
// - Mode 7 is single-chip, one megabyte space, all ports general.
// - Port 3 is the data bus in modes 1, 3, 5; general otherwise.
// - Port A upper pins general except mode 3 address use.
// - Address space splits into eight equal areas per space size in expanded modes; area stays 0 in modes 6, 7.
// - On-chip register addresses depend on the space size.
`timescale 1ns/1ps
`include "pam_consts.svh"
module pam_port_mux
  import pam_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [2:0] modeSelectPins,
  input wire pam_apb_req_t apbReq,
  output pam_apb_rsp_t apbRsp,
  input wire logic [23:0] cpuAddr,
  input wire logic busCycle,
  input wire logic busWrite,
  input wire logic [7:0] cpuWdata,
  input wire logic [7:0] gpOut1,
  input wire logic [7:0] gpOut2,
  input wire logic [7:0] gpOut3,
  input wire logic [3:0] gpOut5,
  input wire logic [3:0] gpOutA,
  input wire logic [7:0] gpDir3,
  input wire logic [3:0] gpDirA,
  output pam_pins_t pins,
  output logic [2:0] areaSel,
  output logic onChipRegSel,
  output logic busWidth16,
  output logic modeIllegal
);

  typedef struct packed {
    pam_mode_t mode;
    logic [7:0] upperAddrCtrl;
    logic [7:0] busRelCtrl;
    logic [7:0] p1Dir;
    logic [7:0] p2Dir;
    logic [3:0] p5Dir;
    pam_apb_rsp_t rsp;
    pam_pins_t pins;
    logic [2:0] area;
    logic regSel;
    logic wide;
    logic illegal;
  } pam_state_t;

  pam_state_t state_reg;
  pam_state_t state_next;

  logic expanded;
  logic dataBus;
  logic [1:0] spaceSel;
  logic [7:0] p1AddrEn;
  logic [7:0] p2AddrEn;
  logic [3:0] p5AddrEn;
  logic [3:0] paAddrEn;
  logic [3:0] paAddrBits;
  logic [7:0] p1Oe;
  logic [7:0] p2Oe;
  logic [3:0] p5Oe;
  logic [3:0] paOe;
  logic [7:0] p1Val;
  logic [7:0] p2Val;
  logic [3:0] p5Val;
  logic [3:0] paVal;
  logic [2:0] areaNum;
  logic onChipRegs;
  logic apbAccess;
  logic [31:0] rdData;

  always_comb begin
    expanded = 1'b0;
    dataBus = 1'b0;
    spaceSel = `PAM_SPACE_1M;
    p1AddrEn = 8'h00;
    p2AddrEn = 8'h00;
    p5AddrEn = 4'h0;
    paAddrEn = 4'h0;
    case (state_reg.mode)
      PAM_MODE_1: begin
        expanded = 1'b1;
        dataBus = 1'b1;
        p1AddrEn = 8'hff;
        p2AddrEn = 8'hff;
        p5AddrEn = 4'hf;
      end
      PAM_MODE_3: begin
        expanded = 1'b1;
        dataBus = 1'b1;
        spaceSel = `PAM_SPACE_16M;
        p1AddrEn = 8'hff;
        p2AddrEn = 8'hff;
        p5AddrEn = 4'hf;
        // Upper three pins wait for zeros in the control field
        paAddrEn[3:1] = ~state_reg.upperAddrCtrl[7:5];
        paAddrEn[0] = 1'b1;
      end
      PAM_MODE_5: begin
        expanded = 1'b1;
        dataBus = 1'b1;
        p1AddrEn = state_reg.p1Dir;
        p2AddrEn = state_reg.p2Dir;
        p5AddrEn = state_reg.p5Dir;
      end
      PAM_MODE_6: begin
        spaceSel = `PAM_SPACE_64K;
      end
      PAM_MODE_7: begin
        spaceSel = `PAM_SPACE_1M;
      end
      default: begin
        spaceSel = `PAM_SPACE_1M;
      end
    endcase
  end

  // Port A upper nibble carries A23..A20, pin 4 holds A20
  assign paAddrBits = cpuAddr[23:20];

  pam_pin_sel #(.WIDTH(8)) uPort1 (
    .addrEn(p1AddrEn),
    .addrBits(cpuAddr[7:0]),
    .gpOut(gpOut1),
    .gpDir(state_reg.p1Dir),
    .pinOut(p1Val),
    .pinOe(p1Oe)
  );

  pam_pin_sel #(.WIDTH(8)) uPort2 (
    .addrEn(p2AddrEn),
    .addrBits(cpuAddr[15:8]),
    .gpOut(gpOut2),
    .gpDir(state_reg.p2Dir),
    .pinOut(p2Val),
    .pinOe(p2Oe)
  );

  pam_pin_sel #(.WIDTH(4)) uPort5 (
    .addrEn(p5AddrEn),
    .addrBits(cpuAddr[19:16]),
    .gpOut(gpOut5),
    .gpDir(state_reg.p5Dir),
    .pinOut(p5Val),
    .pinOe(p5Oe)
  );

  pam_pin_sel #(.WIDTH(4)) uPortA (
    .addrEn(paAddrEn),
    .addrBits(paAddrBits),
    .gpOut(gpOutA),
    .gpDir(gpDirA),
    .pinOut(paVal),
    .pinOe(paOe)
  );

  pam_area_dec uArea (
    .spaceSel(spaceSel),
    .cpuAddr(cpuAddr),
    .areaNum(areaNum),
    .onChipRegs(onChipRegs)
  );

  assign apbAccess = apbReq.psel & apbReq.penable;

  always_comb begin
    case (apbReq.paddr)
      `PAM_ADDR_CTRL: rdData = {24'h000000, state_reg.upperAddrCtrl};
      `PAM_BUS_REL: rdData = {24'h000000, state_reg.busRelCtrl};
      `PAM_P1_DIR: rdData = {24'h000000, state_reg.p1Dir};
      `PAM_P2_DIR: rdData = {24'h000000, state_reg.p2Dir};
      `PAM_P5_DIR: rdData = {28'h0000000, state_reg.p5Dir};
      `PAM_STATUS: rdData = {26'h0, state_reg.illegal, state_reg.wide, 1'b0, state_reg.mode};
      default: rdData = 32'h00000000;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.rsp.pready = 1'b0;
    state_next.rsp.pslverr = 1'b0;
    state_next.rsp.prdata = 32'h00000000;
    // Single-cycle answer: pready rises in the first access cycle's next edge
    if (apbAccess && !state_reg.rsp.pready) begin
      state_next.rsp.pready = 1'b1;
      state_next.rsp.prdata = apbReq.pwrite ? 32'h00000000 : rdData;
      case (apbReq.paddr)
        `PAM_ADDR_CTRL, `PAM_BUS_REL, `PAM_P1_DIR, `PAM_P2_DIR, `PAM_P5_DIR, `PAM_STATUS: begin
          state_next.rsp.pslverr = apbReq.pwrite && apbReq.paddr == `PAM_STATUS;
        end
        default: begin
          state_next.rsp.pslverr = 1'b1;
        end
      endcase
      if (apbReq.pwrite) begin
        case (apbReq.paddr)
          `PAM_ADDR_CTRL: state_next.upperAddrCtrl = apbReq.pwdata[7:0];
          `PAM_BUS_REL: state_next.busRelCtrl = apbReq.pwdata[7:0];
          `PAM_P1_DIR: state_next.p1Dir = apbReq.pwdata[7:0];
          `PAM_P2_DIR: state_next.p2Dir = apbReq.pwdata[7:0];
          `PAM_P5_DIR: state_next.p5Dir = apbReq.pwdata[3:0];
          default: state_next.p5Dir = state_reg.p5Dir;
        endcase
      end
    end
    state_next.pins.p1Oe = p1Oe;
    state_next.pins.p2Oe = p2Oe;
    state_next.pins.p5Oe = p5Oe;
    state_next.pins.paOe = paOe;
    state_next.pins.p1Out = p1Val;
    state_next.pins.p2Out = p2Val;
    state_next.pins.p5Out = p5Val;
    state_next.pins.paOut = paVal;
    if (dataBus) begin
      state_next.pins.p3Oe = (busCycle && busWrite) ? 8'hff : 8'h00;
      state_next.pins.p3Out = cpuWdata;
    end else begin
      state_next.pins.p3Oe = gpDir3;
      state_next.pins.p3Out = gpOut3;
    end
    state_next.area = expanded ? areaNum : 3'h0;
    state_next.regSel = onChipRegs;
    state_next.wide = `PAM_BUS_WIDTH_8;
    state_next.illegal = state_reg.mode == PAM_MODE_2 || state_reg.mode == PAM_MODE_4
      || state_reg.mode == PAM_MODE_NONE;
    if (reset) begin
      state_next = '0;
      state_next.mode = pam_mode_t'(modeSelectPins);
      state_next.upperAddrCtrl = `PAM_UPPER_RST;
      state_next.busRelCtrl = `PAM_BUS_REL_RST;
      state_next.p1Dir = `PAM_DIR_RST;
      state_next.p2Dir = `PAM_DIR_RST;
      state_next.p5Dir = 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    state_reg <= state_next;
  end

  assign apbRsp = state_reg.rsp;
  assign pins = state_reg.pins;
  assign areaSel = state_reg.area;
  assign onChipRegSel = state_reg.regSel;
  assign busWidth16 = state_reg.wide;
  assign modeIllegal = state_reg.illegal;

  a_mode_five_inputs: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(reset) && state_reg.mode == PAM_MODE_5 |-> pins.p1Oe == 8'h00)
    else $error("mode 5 port 1 not input after reset");
  a_mode_five_ddr: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_5 |=> pins.p1Oe == $past(state_reg.p1Dir))
    else $error("mode 5 port 1 enable not following direction");
  a_mode_one_addr: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_1 |=> pins.p2Out == $past(cpuAddr[15:8]) && pins.p5Oe == 4'hf)
    else $error("mode 1 address not on ports");
  a_a20_always: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_3 |=> pins.paOe[0] && pins.paOut[0] == $past(cpuAddr[20]))
    else $error("A20 not driven in mode 3");
  a_upper_gate: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_3 && state_reg.upperAddrCtrl[7] && !gpDirA[3] |=> !pins.paOe[3])
    else $error("A23 driven without enable");
  a_single_chip: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_7 |=> pins.p3Oe == $past(gpDir3) && pins.p1Oe == $past(state_reg.p1Dir))
    else $error("mode 7 ports not general");
  a_mode_six_port: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_6 |=> pins.p3Out == $past(gpOut3))
    else $error("mode 6 port 3 not general");
  a_data_bus: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_3 && busCycle && busWrite |=> pins.p3Oe == 8'hff)
    else $error("data bus not driven on write");
  a_eight_bit: assert property (@(posedge ref_clk) disable iff (reset)
    !busWidth16)
    else $error("bus not 8-bit");
  a_area_16m: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_3 |=> areaSel == $past(cpuAddr[23:21]))
    else $error("16M area decode wrong");

  // Register handshake: access taken, answer one cycle later, then gone
  sequence s_apb_taken;
    apbReq.psel && apbReq.penable && !apbRsp.pready;
  endsequence

  sequence s_apb_answer;
    apbRsp.pready ##1 !apbRsp.pready;
  endsequence

  sequence s_upper_zeroed;
    state_reg.mode == PAM_MODE_3 ##0 s_apb_taken ##0 apbReq.pwrite && apbReq.paddr == `PAM_ADDR_CTRL
      && apbReq.pwdata[7:5] == 3'h0;
  endsequence

  a_apb_one_wait: assert property (@(posedge ref_clk) disable iff (reset)
    s_apb_taken |=> s_apb_answer)
    else $error("register answer not one cycle after access");
  a_upper_enable: assert property (@(posedge ref_clk) disable iff (reset)
    s_upper_zeroed |=> ##1 pins.paOe == 4'hf)
    else $error("upper address pins not enabled after zero write");
  a_addr_24bit: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_3 && state_reg.upperAddrCtrl[7:5] == 3'h0
      |=> pins.paOut == $past(cpuAddr[23:20]) && pins.p5Out == $past(cpuAddr[19:16]))
    else $error("mode 3 upper address lines wrong");
  a_port_a_gp: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode != PAM_MODE_3 |=> pins.paOe == $past(gpDirA) && pins.paOut == $past(gpOutA))
    else $error("port A upper pins not general");
  a_mode_five_p25: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_5
      |=> pins.p2Oe == $past(state_reg.p2Dir) && pins.p5Oe == $past(state_reg.p5Dir))
    else $error("mode 5 ports 2 and 5 enable not following direction");
  a_data_idle: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode inside {PAM_MODE_1, PAM_MODE_3, PAM_MODE_5} && !(busCycle && busWrite)
      |=> pins.p3Oe == 8'h00)
    else $error("data bus driven outside a write");
  a_mode_latch: assert property (@(posedge ref_clk)
    reset |=> state_reg.mode == $past(modeSelectPins))
    else $error("mode not latched during reset");
  a_mode_frozen: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> $stable(state_reg.mode))
    else $error("mode changed while running");
  a_area_1m: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_1 || state_reg.mode == PAM_MODE_5 |=> areaSel == $past(cpuAddr[19:17]))
    else $error("1M area decode wrong");
  a_single_area: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_6 || state_reg.mode == PAM_MODE_7 |=> areaSel == 3'h0)
    else $error("single-chip area not zero");
  a_regs_64k: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg.mode == PAM_MODE_6 && cpuAddr[15:8] == 8'hff |=> onChipRegSel)
    else $error("64k register window not decoded");
endmodule // pam_port_mux

// >>> test/mode_dependent_port_address_mux_bench.sv
// Self-checking bench for the mode-dependent port and address multiplexer.
// Assumes the design package and the external memory model.
`timescale 1ns/1ps
module mode_dependent_port_address_mux_bench
  import pam_pkg::*;
;
  logic ref_clk;
  logic reset;
  logic [2:0] modeSelectPins;
  pam_apb_req_t apbReq;
  pam_apb_rsp_t apbRsp;
  logic [23:0] cpuAddr;
  logic busCycle;
  logic busWrite;
  logic [7:0] cpuWdata;
  logic [7:0] gpOut1;
  logic [7:0] gpOut2;
  logic [7:0] gpOut3;
  logic [3:0] gpOut5;
  logic [3:0] gpOutA;
  logic [7:0] gpDir3;
  logic [3:0] gpDirA;
  pam_pins_t pins;
  logic [2:0] areaSel;
  logic onChipRegSel;
  logic busWidth16;
  logic modeIllegal;
  logic [23:0] memAddr;
  logic [7:0] memData;
  logic [31:0] rd;
  logic err;
  int bad_count;
  int checks;

  pam_port_mux uut (.ref_clk(ref_clk), .reset(reset), .modeSelectPins(modeSelectPins), .apbReq(apbReq),
    .apbRsp(apbRsp), .cpuAddr(cpuAddr), .busCycle(busCycle), .busWrite(busWrite), .cpuWdata(cpuWdata),
    .gpOut1(gpOut1), .gpOut2(gpOut2), .gpOut3(gpOut3), .gpOut5(gpOut5), .gpOutA(gpOutA), .gpDir3(gpDir3),
    .gpDirA(gpDirA), .pins(pins), .areaSel(areaSel), .onChipRegSel(onChipRegSel), .busWidth16(busWidth16),
    .modeIllegal(modeIllegal));
  pam_ext_mem mem0 (.ref_clk(ref_clk), .pins(pins), .memAddr(memAddr), .memData(memData));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic finish_test;
    begin
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        bad_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task automatic settle;
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge ref_clk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge ref_clk);
      apbReq.penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      do begin
        @(posedge ref_clk);
        n++;
      end while (apbRsp.pready !== 1'b1);
      chk(n, 32'h2);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq <= '0;
    end
  endtask

  // Mode pins are set while reset is high; t_mode1 later changes them with reset low
  task automatic rst(input logic [2:0] m);
    begin
      @(posedge ref_clk);
      reset <= 1'b1;
      modeSelectPins <= m;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      apb(1'b0, 8'h14, 32'h0);
      chk(rd, {26'h0, (m == 3'h2 || m == 3'h4), 2'b00, m});
    end
  endtask

  task automatic t_mode1;
    begin
      rst(3'h1);
      @(posedge ref_clk);
      cpuAddr <= 24'habcde5;
      busCycle <= 1'b1;
      busWrite <= 1'b1;
      cpuWdata <= 8'h5a;
      settle;
      chk({pins.p5Out, pins.p2Out, pins.p1Out}, 32'hbcde5);
      chk({pins.p5Oe, pins.p2Oe, pins.p1Oe}, 32'hfffff);
      chk(pins.paOe, 32'h0);
      chk(pins.p3Oe, 32'hff);
      chk(areaSel, 32'h5);
      chk(busWidth16, 32'h0);
      settle;
      chk(memData, 32'h5a);
      chk(memAddr, 32'h0bcde5);
      @(posedge ref_clk);
      modeSelectPins <= 3'h6;
      settle;
      settle;
      chk(pins.p1Oe, 32'hff);
    end
  endtask

  task automatic t_mode3;
    begin
      rst(3'h3);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'he0);
      @(posedge ref_clk);
      cpuAddr <= 24'hb00000;
      busCycle <= 1'b0;
      settle;
      chk(pins.paOe, 32'h1);
      chk(pins.paOut[0], 32'h1);
      chk(areaSel, 32'h5);
      chk(pins.p3Oe, 32'h0);
      apb(1'b1, 8'h00, 32'h0);
      settle;
      chk(pins.paOe, 32'hf);
      chk(pins.paOut, 32'hb);
    end
  endtask

  task automatic t_mode5;
    begin
      rst(3'h5);
      @(posedge ref_clk);
      cpuAddr <= 24'h012345;
      busCycle <= 1'b1;
      cpuWdata <= 8'hc3;
      settle;
      chk({pins.p5Oe, pins.p2Oe, pins.p1Oe}, 32'h0);
      chk(pins.p3Out, 32'hc3);
      apb(1'b1, 8'h08, 32'h0f);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0f);
      settle;
      chk(pins.p1Oe, 32'h0f);
      chk(pins.p1Out & 8'h0f, 32'h5);
      apb(1'b1, 8'h10, 32'h3);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'he0);
      settle;
      chk(pins.p5Oe, 32'h3);
      chk(pins.p5Out & 4'h3, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'hff);
      apb(1'b0, 8'h20, 32'h0);
      chk(err, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 8'h14, 32'hff);
      chk(err, 32'h1);
    end
  endtask

  task automatic t_single(input logic [2:0] m, input logic [23:0] top);
    begin
      rst(m);
      @(posedge ref_clk);
      gpDir3 <= 8'h3c;
      gpOut3 <= 8'ha5;
      gpDirA <= 4'h9;
      cpuAddr <= top;
      settle;
      chk(pins.p3Oe, 32'h3c);
      chk(pins.p3Out & 8'h3c, 32'h24);
      chk(pins.paOe, 32'h9);
      chk(pins.p1Oe, 32'h0);
      chk(areaSel, 32'h0);
      chk(onChipRegSel, 32'h1);
      @(posedge ref_clk);
      cpuAddr <= top - 24'h000001;
      settle;
      chk(onChipRegSel, 32'h0);
      @(posedge ref_clk);
      gpDirA <= 4'h0;
    end
  endtask

  initial begin
    reset = 1'b1;
    modeSelectPins = 3'h1;
    apbReq = '0;
    cpuAddr = 24'h000000;
    busCycle = 1'b0;
    busWrite = 1'b0;
    cpuWdata = 8'h00;
    gpOut1 = 8'h11;
    gpOut2 = 8'h22;
    gpOut3 = 8'h33;
    gpOut5 = 4'h5;
    gpOutA = 4'h6;
    gpDir3 = 8'h00;
    gpDirA = 4'h0;
    bad_count = 0;
    checks = 0;
    t_mode1;
    t_mode3;
    t_mode5;
    t_single(3'h6, 24'h00ff00);
    t_single(3'h7, 24'h0fff00);
    // Unsupported modes are driven on purpose to see them flagged
    rst(3'h2);
    settle;
    chk(modeIllegal, 32'h1);
    rst(3'h4);
    settle;
    chk(modeIllegal, 32'h1);
    finish_test;
  end

  initial begin
    #(50 * 5000);
    bad_count++;
    finish_test;
  end
endmodule // mode_dependent_port_address_mux_bench

// >>> test/pam_ext_mem.sv
// Model of an external memory on the expanded bus: latches each write cycle.
// Assumes the pin struct of the multiplexer; it drives no pin back.
`timescale 1ns/1ps
module pam_ext_mem
  import pam_pkg::*;
(
  input wire logic ref_clk,
  input wire pam_pins_t pins,
  output logic [23:0] memAddr,
  output logic [7:0] memData
);
  initial begin
    memAddr = 24'h000000;
    memData = 8'h00;
  end
  // Only driven address pins are seen; released pins read as zero
  always @(posedge ref_clk) begin
    if (pins.p3Oe == 8'hff) begin
      memAddr <= {pins.paOut & pins.paOe, pins.p5Out & pins.p5Oe, pins.p2Out & pins.p2Oe, pins.p1Out & pins.p1Oe};
      memData <= pins.p3Out;
    end
  end
endmodule // pam_ext_mem
